// file: fw_mem_model.sv
// Behavioural firmware memory answering segment commands
`timescale 1ns/1ns
module fw_mem_model (
  input  wire logic        clk,   // System clock
  input  wire logic        erase, // Erase pulse
  input  wire logic        wr,    // Write pulse
  input  wire logic        rd,    // Read pulse
  input  wire logic [15:0] seg,   // Segment number
  input  wire logic [31:0] wd,    // Write data
  output logic             done,  // Op finished
  output logic [31:0]      rdd    // Read data
);
  logic [31:0] mem [16];
  logic [3:0]  wait_q = 4'h0;
  initial begin
    done = 1'b0;
    rdd  = 32'h0;
    foreach (mem[i]) mem[i] = 32'h0;
  end
  // Answers within 8 cycles; the real erase is far slower
  always @(posedge clk) begin
    done <= 1'b0;
    rdd  <= ~rdd; // Garbage outside done
    if (erase) foreach (mem[i]) mem[i] <= 32'hffff_ffff;
    if (wr) mem[seg[3:0]] <= wd;
    if (erase | wr | rd) wait_q <= 4'(1 + $urandom % 8);
    else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
      if (wait_q == 4'h1) begin
        done <= 1'b1;
        rdd  <= mem[seg[3:0]];
      end
    end
  end
endmodule : fw_mem_model

// file: scope_link_cfg.sv
// Trace capture engine with firmware maintenance and staged link settings
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`include "scope_params.svh"

module scope_link_cfg import scope_pkg::*; #(
  parameter int          DEPTH    = `TRACE_LEN,
  parameter int          SW       = 16,
  parameter logic [31:0] KEY_REV  = 32'h0000_0001, // Arbitrary value
  parameter logic [31:0] SVC_KEY  = 32'h0000_5a5a, // Arbitrary value
  parameter logic [15:0] ETH_PORT = 16'h0400
) (
  input  wire logic          clk,          // System clock
  input  wire logic          rst,          // Sync reset
  input  wire logic          ce,           // Clock enable
  input  wire logic [7:0]    awaddr,       // AXI write addr
  input  wire logic          awvalid,      // AXI
  output logic               awready,      // AXI
  input  wire logic [31:0]   wdata,        // AXI write data
  input  wire logic [3:0]    wstrb,        // AXI byte enables
  input  wire logic          wvalid,       // AXI
  output logic               wready,       // AXI
  output logic [1:0]         bresp,        // AXI
  output logic               bvalid,       // AXI
  input  wire logic          bready,       // AXI
  input  wire logic [7:0]    araddr,       // AXI read addr
  input  wire logic          arvalid,      // AXI
  output logic               arready,      // AXI
  output logic [31:0]        rdata,        // AXI read data
  output logic [1:0]         rresp,        // AXI
  output logic               rvalid,       // AXI
  input  wire logic          rready,       // AXI
  input  wire logic [SW-1:0] s_adc,        // Converter data
  input  wire logic [SW-1:0] s_fast,       // Fast filter
  input  wire logic [SW-1:0] s_med,        // Medium filter
  input  wire logic [SW-1:0] s_slow,       // Slow filter
  input  wire logic [SW-1:0] s_bl_avg,     // Baseline average
  input  wire logic [SW-1:0] s_bl_smp,     // Baseline samples
  input  wire logic [12:0]   evt,          // Event pulses, by trig code
  input  wire logic [15:0]   out_bin,      // Bin of current output count
  input  wire logic [47:0]   serial_no,    // Device serial number
  input  wire logic          fw_done,      // Memory op finished
  input  wire logic [31:0]   fw_rd_data,   // Memory read data
  output logic               fw_erase,     // Erase update area
  output logic               fw_wr,        // Write segment
  output logic               fw_rd,        // Read segment
  output logic [15:0]        fw_seg,       // Segment number
  output logic [31:0]        fw_wdata,     // Segment data
  output logic               eth_pwr_en,   // Ethernet power
  output logic               usb_pwr_en,   // USB power
  output logic               spi_en,       // SPI accepts traffic
  output logic               eth_udp,      // Transport is UDP
  output logic [2:0]         eth_speed,    // Speed/duplex mode
  output logic [31:0]        eth_ip,       // Active address
  output logic [31:0]        eth_mask,     // Active mask
  output logic [31:0]        eth_gw,       // Active gateway
  output logic               eth_reconfig  // Pulse: reconfigure, drop links
);

  localparam int IW = $clog2(DEPTH);
  localparam logic [7:0] TICK_N = 8'(`TICK_CYC);

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic aw_full_q, aw_full_d, w_full_q, w_full_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rdata_q, rdata_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [3:0]  src_q, src_d;
  logic [15:0] tval_q, tval_d, samp_q, samp_d, seg_q, seg_d;
  logic [31:0] tout_q, tout_d, svc_q, svc_d, fwd_q, fwd_d;
  logic [2:0]  wsel_q, wsel_d, pd_q, pd_d, spd_p_q, spd_p_d;
  logic [IW-1:0] tidx_q, tidx_d;
  logic        udp_p_q, udp_p_d;
  logic [31:0] ip_p_q, ip_p_d, mask_p_q, mask_p_d, gw_p_q, gw_p_d;
  logic        wr_go, wr_hit, rd_hit;
  logic [31:0] wv, rd_val, wr_cur;
  logic        c_start, c_apply, c_erase, c_fwwr, c_fwrd;

  cap_e        st_q, st_d;
  logic [SW-1:0] buf_q [DEPTH];
  logic        fw_busy_q, fw_err_q, fw_rdop_q;
  logic [31:0] fw_rdat_q;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) o[8*i +: 8] = n[8*i +: 8];
    end
    return o;
  endfunction : merge

  function automatic logic [32:0] rmux(input logic [7:0] a);
    unique case (a)
      `A_CTRL:      rmux = {1'b1, 32'h0};
      `A_STATUS:    rmux = {1'b1, 27'h0, fw_err_q, fw_busy_q, st_q == CAP_TOUT,
                            st_q == CAP_DONE, st_q == CAP_ARM || st_q == CAP_FILL};
      `A_TRIG_SRC:  rmux = {1'b1, 28'h0, src_q};
      `A_TRIG_VAL:  rmux = {1'b1, 16'h0, tval_q};
      `A_SAMP_INT:  rmux = {1'b1, 16'h0, samp_q};
      `A_TIMEOUT:   rmux = {1'b1, tout_q};
      `A_WAVE_SEL:  rmux = {1'b1, 29'h0, wsel_q};
      `A_TRACE_IDX: rmux = {1'b1, 32'(tidx_q)};
      `A_TRACE_DAT: rmux = {1'b1, 32'(buf_q[tidx_q])};
      `A_KEY_REV:   rmux = {1'b1, KEY_REV};
      `A_SVC_CODE:  rmux = {1'b1, svc_q};
      `A_FW_SEG:    rmux = {1'b1, 16'h0, seg_q};
      `A_FW_DATA:   rmux = {1'b1, fw_rdat_q};
      `A_PWR_DOWN:  rmux = {1'b1, 29'h0, pd_q};
      `A_ETH_PROTO: rmux = {1'b1, 31'h0, udp_p_q};
      `A_ETH_SPEED: rmux = {1'b1, 29'h0, spd_p_q};
      `A_ETH_IP:    rmux = {1'b1, ip_p_q};
      `A_ETH_MASK:  rmux = {1'b1, mask_p_q};
      `A_ETH_GW:    rmux = {1'b1, gw_p_q};
      `A_ETH_PORT:  rmux = {1'b1, 16'h0, ETH_PORT};
      `A_MAC_LO:    rmux = {1'b1, serial_no[31:0]};
      `A_MAC_HI:    rmux = {1'b1, 16'h0, serial_no[47:32]};
      default:      rmux = {1'b0, 32'h0};
    endcase
  endfunction : rmux

  assign awready = ce && !aw_full_q;
  assign wready  = ce && !w_full_q;
  assign arready = ce && !rvalid_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;
  assign wr_go   = ce && aw_full_q && w_full_q && !bvalid_q;
  // Process, not assign: lookup must rerun when any register behind it moves
  always_comb begin
    {wr_hit, wr_cur} = rmux(awa_q);
    {rd_hit, rd_val} = rmux(araddr);
  end
  assign wv      = merge(wr_cur, wd_q, ws_q);
  // Command bits are pulses, not stored
  assign c_start = wr_go && awa_q == `A_CTRL && ws_q[0] && wd_q[`C_START];
  assign c_apply = wr_go && awa_q == `A_CTRL && ws_q[0] && wd_q[`C_APPLY];
  assign c_erase = wr_go && awa_q == `A_CTRL && ws_q[0] && wd_q[`C_ERASE];
  assign c_fwwr  = wr_go && awa_q == `A_CTRL && ws_q[0] && wd_q[`C_FW_WR];
  assign c_fwrd  = wr_go && awa_q == `A_CTRL && ws_q[0] && wd_q[`C_FW_RD];

  always_comb begin
    {aw_full_d, awa_d, w_full_d, wd_d, ws_d} = {aw_full_q, awa_q, w_full_q, wd_q, ws_q};
    {bvalid_d, bresp_d, rvalid_d, rdata_d, rresp_d} = {bvalid_q, bresp_q, rvalid_q, rdata_q, rresp_q};
    {src_d, tval_d, samp_d, tout_d, wsel_d, tidx_d} = {src_q, tval_q, samp_q, tout_q, wsel_q, tidx_q};
    {svc_d, seg_d, fwd_d, pd_d} = {svc_q, seg_q, fwd_q, pd_q};
    {udp_p_d, spd_p_d, ip_p_d, mask_p_d, gw_p_d} = {udp_p_q, spd_p_q, ip_p_q, mask_p_q, gw_p_q};
    if (awvalid && awready) begin
      aw_full_d = 1'b1;
      awa_d     = awaddr;
    end
    if (wvalid && wready) begin
      w_full_d = 1'b1;
      wd_d     = wdata;
      ws_d     = wstrb;
    end
    if (bvalid_q && bready) bvalid_d = 1'b0;
    if (wr_go) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      unique case (awa_q)
        `A_TRIG_SRC:  src_d    = wv[3:0];
        `A_TRIG_VAL:  tval_d   = wv[15:0];
        `A_SAMP_INT:  samp_d   = wv[15:0];
        `A_TIMEOUT:   tout_d   = wv;
        `A_WAVE_SEL:  wsel_d   = wv[2:0];
        `A_TRACE_IDX: tidx_d   = wv[IW-1:0];
        `A_SVC_CODE:  svc_d    = wv;
        `A_FW_SEG:    seg_d    = wv[15:0];
        `A_FW_DATA:   fwd_d    = wv;
        `A_PWR_DOWN:  pd_d     = wv[2:0];
        `A_ETH_PROTO: udp_p_d  = wv[0];
        `A_ETH_SPEED: spd_p_d  = (wv[2:0] > SPD_H10) ? spd_p_q : wv[2:0];
        `A_ETH_IP:    ip_p_d   = wv;
        `A_ETH_MASK:  mask_p_d = wv;
        `A_ETH_GW:    gw_p_d   = wv;
        default: ;
      endcase
    end
    if (rvalid_q && rready) rvalid_d = 1'b0;
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rdata_d  = rd_val;
      rresp_d  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      {aw_full_q, w_full_q, bvalid_q, rvalid_q} <= 4'h0;
      {awa_q, wd_q, ws_q, bresp_q, rdata_q, rresp_q} <= '0;
      {src_q, tval_q, tout_q, wsel_q, tidx_q} <= {TRG_INSTANT, 16'h0, `RST_TOUT, WV_ADC, IW'(0)};
      samp_q <= `RST_SAMP;
      {svc_q, seg_q, fwd_q, pd_q} <= '0;
      {udp_p_q, spd_p_q} <= {1'b0, SPD_AUTO};
      {ip_p_q, mask_p_q, gw_p_q} <= {`RST_IP, `RST_MASK, `RST_GW};
    end else if (ce) begin
      {aw_full_q, awa_q, w_full_q, wd_q, ws_q} <= {aw_full_d, awa_d, w_full_d, wd_d, ws_d};
      {bvalid_q, bresp_q, rvalid_q, rdata_q, rresp_q} <= {bvalid_d, bresp_d, rvalid_d, rdata_d, rresp_d};
      {src_q, tval_q, samp_q, tout_q, wsel_q, tidx_q} <= {src_d, tval_d, samp_d, tout_d, wsel_d, tidx_d};
      {svc_q, seg_q, fwd_q, pd_q} <= {svc_d, seg_d, fwd_d, pd_d};
      {udp_p_q, spd_p_q, ip_p_q, mask_p_q, gw_p_q} <= {udp_p_d, spd_p_d, ip_p_d, mask_p_d, gw_p_d};
    end
  end

  // ----------------------------------------------------------------
  // Trace capture
  // ----------------------------------------------------------------
  logic [15:0]   div_q, div_d, n_eff;
  logic [IW-1:0] idx_q, idx_d;
  logic [7:0]    pre_q, pre_d;
  logic [31:0]   tcnt_q, tcnt_d;
  logic [SW-1:0] smp;
  logic          tick, trig_hit;

  // Interval of zero would never sample, so it acts as one
  assign n_eff = (samp_q == 16'h0) ? 16'h0001 : samp_q;
  assign tick  = div_q == n_eff - 16'h0001;

  always_comb begin
    unique case (trig_e'(src_q))
      TRG_INSTANT: trig_hit = 1'b1;
      TRG_ADC_VAL: trig_hit = s_adc == SW'(tval_q);
      TRG_OUT_BIN: trig_hit = evt[TRG_OUT_ANY] && out_bin == tval_q;
      default:     trig_hit = (src_q <= TRG_ADC_VAL) && evt[src_q];
    endcase
  end

  always_comb begin
    unique case (wave_e'(wsel_q))
      WV_ADC:    smp = s_adc;
      WV_FAST:   smp = s_fast;
      WV_MED:    smp = s_med;
      WV_SLOW:   smp = s_slow;
      WV_BL_AVG: smp = s_bl_avg;
      WV_BL_SMP: smp = s_bl_smp;
      default:   smp = s_adc;
    endcase
  end

  always_comb begin
    {st_d, div_d, idx_d, pre_d, tcnt_d} = {st_q, div_q, idx_q, pre_q, tcnt_q};
    unique case (st_q)
      CAP_IDLE, CAP_DONE, CAP_TOUT: begin
        // Start only honoured here; busy states drop it
        if (c_start) begin
          st_d   = CAP_ARM;
          pre_d  = 8'h0;
          tcnt_d = 32'h0;
        end
      end
      CAP_ARM: begin
        if (trig_hit) begin
          st_d  = CAP_FILL;
          div_d = 16'h0;
          idx_d = '0;
        end else if (tcnt_q >= tout_q) begin
          st_d = CAP_TOUT;
        end else if (pre_q == TICK_N - 8'h01) begin
          pre_d  = 8'h0;
          tcnt_d = tcnt_q + 32'h1;
        end else begin
          pre_d = pre_q + 8'h01;
        end
      end
      CAP_FILL: begin
        div_d = tick ? 16'h0 : div_q + 16'h0001;
        if (tick) begin
          idx_d = idx_q + IW'(1);
          if (idx_q == IW'(DEPTH - 1)) st_d = CAP_DONE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= CAP_IDLE;
      {div_q, idx_q, pre_q, tcnt_q} <= '0;
    end else if (ce) begin
      {st_q, div_q, idx_q, pre_q, tcnt_q} <= {st_d, div_d, idx_d, pre_d, tcnt_d};
    end
  end

  // Trace store is not reset; contents only valid after a done capture
  always_ff @(posedge clk) begin
    if (ce && st_q == CAP_FILL && tick) buf_q[idx_q] <= smp;
  end

  // ----------------------------------------------------------------
  // Firmware maintenance
  // ----------------------------------------------------------------
  logic fw_busy_d, fw_err_d, fw_rdop_d, fw_erase_d, fw_wr_d, fw_rd_d, svc_ok;
  logic [31:0] fw_rdat_d;

  assign svc_ok = svc_q == SVC_KEY;

  always_comb begin
    {fw_busy_d, fw_err_d, fw_rdop_d, fw_rdat_d} = {fw_busy_q, fw_err_q, fw_rdop_q, fw_rdat_q};
    {fw_erase_d, fw_wr_d, fw_rd_d} = 3'h0;
    if (fw_busy_q && fw_done) begin
      fw_busy_d = 1'b0;
      if (fw_rdop_q) fw_rdat_d = fw_rd_data;
    end
    // Commands while busy are dropped; one memory op at a time
    if (!fw_busy_q && (c_erase || c_fwwr || c_fwrd)) begin
      fw_err_d  = 1'b0;
      fw_rdop_d = c_fwrd && !c_erase && !c_fwwr;
      if (c_erase) begin
        if (svc_ok) begin
          fw_erase_d = 1'b1;
          fw_busy_d  = 1'b1;
        end else begin
          fw_err_d = 1'b1;
        end
      end else begin
        fw_wr_d   = c_fwwr;
        fw_rd_d   = c_fwrd && !c_fwwr;
        fw_busy_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      {fw_busy_q, fw_err_q, fw_rdop_q, fw_erase, fw_wr, fw_rd} <= 6'h0;
      fw_rdat_q <= 32'h0;
    end else if (ce) begin
      {fw_busy_q, fw_err_q, fw_rdop_q, fw_rdat_q} <= {fw_busy_d, fw_err_d, fw_rdop_d, fw_rdat_d};
      {fw_erase, fw_wr, fw_rd} <= {fw_erase_d, fw_wr_d, fw_rd_d};
    end
  end

  assign fw_seg   = seg_q;
  assign fw_wdata = fwd_q;

  // ----------------------------------------------------------------
  // Link settings and power
  // ----------------------------------------------------------------
  logic        udp_d, reconf_d;
  logic [2:0]  spd_d;
  logic [31:0] ip_d, mask_d, gw_d;

  always_comb begin
    {udp_d, spd_d, ip_d, mask_d, gw_d} = {eth_udp, eth_speed, eth_ip, eth_mask, eth_gw};
    reconf_d = 1'b0;
    if (c_apply) begin
      {udp_d, spd_d, ip_d, mask_d, gw_d} = {udp_p_q, spd_p_q, ip_p_q, mask_p_q, gw_p_q};
      reconf_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      {eth_udp, eth_speed, eth_reconfig} <= {1'b0, SPD_AUTO, 1'b0};
      {eth_ip, eth_mask, eth_gw} <= {`RST_IP, `RST_MASK, `RST_GW};
    end else if (ce) begin
      {eth_udp, eth_speed, eth_ip, eth_mask, eth_gw} <= {udp_d, spd_d, ip_d, mask_d, gw_d};
      eth_reconfig <= reconf_d;
    end
  end

  assign eth_pwr_en = !pd_q[`P_ETH];
  assign usb_pwr_en = !pd_q[`P_USB];
  assign spi_en     = !pd_q[`P_SPI];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  a_sample_pace: assert property (st_q == CAP_FILL && tick && n_eff != 16'h0001 |=> !tick)
    else $error("sample taken off interval");
  a_timeout_abort: assert property (st_q == CAP_ARM && !trig_hit && tcnt_q >= tout_q
                                    |=> st_q == CAP_TOUT)
    else $error("timeout did not abort capture");
  a_fill_length: assert property (st_q == CAP_FILL && tick && idx_q == IW'(DEPTH - 1)
                                  |=> st_q == CAP_DONE && idx_q == '0)
    else $error("trace length wrong");
  a_no_restart: assert property ((st_q == CAP_FILL || st_q == CAP_ARM) && c_start
                                 |=> st_q != CAP_ARM || pre_q != 8'h0 || $past(pre_q) == TICK_N - 8'h01)
    else $error("capture restarted while busy");
  a_erase_gate: assert property (c_erase && !fw_busy_q && !svc_ok
                                 |=> fw_err_q && !fw_erase && !fw_busy_q)
    else $error("erase without service code not refused");
  a_erase_key: assert property (fw_erase |-> $past(svc_ok))
    else $error("erase issued without service code");
  a_eth_hold: assert property (!c_apply |=> $stable(eth_ip) && $stable(eth_udp)
                               && $stable(eth_speed) && !eth_reconfig)
    else $error("link setting changed without apply");
  a_eth_apply: assert property (c_apply |=> eth_reconfig && eth_ip == $past(ip_p_q)
                                && eth_gw == $past(gw_p_q))
    else $error("apply did not load pending settings");
  a_spi_block: assert property (pd_q[`P_SPI] |-> !spi_en && eth_pwr_en == !pd_q[`P_ETH])
    else $error("power-down not honoured");

  c_capture_done: cover property (st_q == CAP_FILL ##1 st_q == CAP_DONE);
  c_capture_tout: cover property (st_q == CAP_ARM ##1 st_q == CAP_TOUT);
  c_eth_apply:    cover property (eth_reconfig);
  c_fw_erase:     cover property (fw_erase ##[1:20] fw_done);

endmodule : scope_link_cfg

// file: scope_params.svh
// Offsets, field positions, reset values and timing counts for the scope and link block
`ifndef SCOPE_PARAMS_SVH
`define SCOPE_PARAMS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ     50
`define TICK_US     1
`define TICK_CYC    (`TICK_US * `CLK_MHZ)
`define TRACE_LEN   8192

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define A_CTRL      8'h00
`define A_STATUS    8'h04
`define A_TRIG_SRC  8'h08
`define A_TRIG_VAL  8'h0c
`define A_SAMP_INT  8'h10
`define A_TIMEOUT   8'h14
`define A_WAVE_SEL  8'h18
`define A_TRACE_IDX 8'h1c
`define A_TRACE_DAT 8'h20
`define A_KEY_REV   8'h24
`define A_SVC_CODE  8'h28
`define A_FW_SEG    8'h2c
`define A_FW_DATA   8'h30
`define A_PWR_DOWN  8'h34
`define A_ETH_PROTO 8'h38
`define A_ETH_SPEED 8'h3c
`define A_ETH_IP    8'h40
`define A_ETH_MASK  8'h44
`define A_ETH_GW    8'h48
`define A_ETH_PORT  8'h4c
`define A_MAC_LO    8'h50
`define A_MAC_HI    8'h54

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define C_START     0
`define C_APPLY     1
`define C_ERASE     2
`define C_FW_WR     3
`define C_FW_RD     4
`define P_ETH       0
`define P_USB       1
`define P_SPI       2

// ----------------------------------------------------------------
// Reset values and bus response codes
// ----------------------------------------------------------------
`define RST_SAMP    16'h0001
`define RST_TOUT    32'h000f_4240
`define RST_IP      32'hc0a8_0001
`define RST_MASK    32'hffff_ff00
`define RST_GW      32'hc0a8_00fe
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// file: scope_pkg.sv
// Types shared by the scope capture and link configuration block
package scope_pkg;

  typedef enum logic [2:0] {
    CAP_IDLE = 3'b000,
    CAP_ARM  = 3'b001,
    CAP_FILL = 3'b010,
    CAP_DONE = 3'b011,
    CAP_TOUT = 3'b100
  } cap_e;

  typedef enum logic [3:0] {
    TRG_ADC_OOR   = 4'b0000, TRG_RST_INIT = 4'b0001, TRG_FAST_PU  = 4'b0010,
    TRG_FAST_RST  = 4'b0011, TRG_FAST_TRG = 4'b0100, TRG_INSTANT  = 4'b0101,
    TRG_MED_PU    = 4'b0110, TRG_MED_RST  = 4'b0111, TRG_MED_TRG  = 4'b1000,
    TRG_BL_SMP    = 4'b1001, TRG_OUT_ANY  = 4'b1010, TRG_OUT_BIN  = 4'b1011,
    TRG_ADC_VAL   = 4'b1100
  } trig_e;

  typedef enum logic [2:0] {
    WV_ADC = 3'b000, WV_FAST = 3'b001, WV_MED = 3'b010,
    WV_SLOW = 3'b011, WV_BL_AVG = 3'b100, WV_BL_SMP = 3'b101
  } wave_e;

  typedef enum logic [2:0] {
    SPD_AUTO = 3'b000, SPD_F100 = 3'b001, SPD_F10 = 3'b010,
    SPD_H100 = 3'b011, SPD_H10 = 3'b100
  } speed_e;

endpackage : scope_pkg

// file: tb_top.sv
// Self-checking bench for the scope capture and link block
`timescale 1ns/1ns
`define CHK(n,e,g) begin n_compared++; if ((g)!==(e)) begin n_fail++; $display("BAD %s exp %h got %h",n,e,g); end end
module tb_top import scope_pkg::*;;
  logic        clk = 0, rst = 1, ce = 1, bready = 1, rready = 1, awvalid = 0, wvalid = 0, arvalid = 0;
  logic [3:0]  wstrb = 4'hf;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [11:0] c = '0;
  logic [12:0] evt = '0;
  logic [15:0] out_bin = '0, s0, fw_seg;
  logic [31:0] wdata = '0, v, d, ex = 32'hc0a8_0001, rdata, fw_rd_data, fw_wdata, eth_ip, eth_mask, eth_gw;
  logic [47:0] serial_no = '0;
  logic [1:0]  bresp, rresp, rs;
  logic [2:0]  eth_speed;
  logic        awready, wready, bvalid, arready, rvalid, fw_done, fw_erase, fw_wr, fw_rd;
  logic        eth_pwr_en, usb_pwr_en, spi_en, eth_udp, eth_reconfig;
  int          n_fail = 0, n_compared = 0, n, n_rc = 0;
  scope_link_cfg #(.DEPTH(16)) scope_link_cfg_inst (.clk, .rst, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .s_adc({4'h0, c}), .s_fast({4'h1, c}), .s_med({4'h2, c}), .s_slow({4'h3, c}), .s_bl_avg({4'h4, c}),
    .s_bl_smp({4'h5, c}), .evt, .out_bin, .serial_no, .fw_done, .fw_rd_data, .fw_erase, .fw_wr, .fw_rd, .fw_seg,
    .fw_wdata, .eth_pwr_en, .usb_pwr_en, .spi_en, .eth_udp, .eth_speed, .eth_ip, .eth_mask, .eth_gw, .eth_reconfig);
  fw_mem_model fw_mem_model_inst (.clk, .erase(fw_erase), .wr(fw_wr), .rd(fw_rd), .seg(fw_seg), .wd(fw_wdata),
    .done(fw_done), .rdd(fw_rd_data));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    c   <= c + 12'h1;
    evt <= 13'($urandom) & 13'h1ffe; // Bit 0 kept low so source 0 never fires
    if (eth_reconfig) n_rc <= n_rc + 1;
  end
  // ----
  // Bus tasks, ready sampled mid-cycle since inputs move only at edges
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    logic ta, tw, tb;
    awaddr <= a; wdata <= x; awvalid <= 1'b1; wvalid <= 1'b1; tb = 1'b0;
    while (!tb) begin
      @(negedge clk); ta = awvalid & awready; tw = wvalid & wready; tb = bvalid; rs = bresp;
      @(posedge clk); if (ta) awvalid <= 1'b0; if (tw) wvalid <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    araddr <= a; arvalid <= 1'b1; tr = 1'b0;
    while (!tr) begin
      @(negedge clk); ta = arvalid & arready; tr = rvalid; v = rdata; rs = rresp;
      @(posedge clk); if (ta) arvalid <= 1'b0;
    end
  endtask : rd
  task automatic fwait();
    do rd(8'h04); while (v[3]);
  endtask : fwait
  function automatic logic [15:0] later(input logic [15:0] s, input int k);
    return {s[15:12], s[11:0] + 12'(k)};
  endfunction : later
  task automatic tdone(input string s);
    $display("test %s finished", s);
  endtask : tdone
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    #1_900_000; n_fail++; summarize();
  end
  initial begin
    void'($urandom(59728));
    serial_no = 48'({$urandom, $urandom});
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(8'h10); `CHK("samp", 32'h1, v)
    rd(8'h24); `CHK("key", 32'h1, v)
    rd(8'h50); `CHK("maclo", serial_no[31:0], v)
    rd(8'h54); `CHK("machi", {16'h0, serial_no[47:32]}, v)
    rd(8'h58); `CHK("unmap", 2'h2, rs)
    wr(8'h58, 32'h0); `CHK("wunmap", 2'h2, rs)
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("cefrz", 3'h0, {awready, wready, arready})
    ce <= 1'b1;
    tdone("regs");
    for (int k = 0; k < 5; k++) begin
      d = $urandom; wr(8'h40, d); wr(8'h44, ~d); wr(8'h48, {d[15:0], d[31:16]}); wr(8'h3c, k); wr(8'h38, k & 1);
      `CHK("wok", 2'h0, rs)
      `CHK("pend", ex, eth_ip)
      wr(8'h00, 32'h2); @(posedge clk); ex = d;
      `CHK("ip", ex, eth_ip)
      `CHK("mask", ~d, eth_mask)
      `CHK("gw", {d[15:0], d[31:16]}, eth_gw)
      `CHK("reconf", k + 1, n_rc)
      `CHK("spd", 3'(k), eth_speed)
      `CHK("udp", 1'(k), eth_udp)
    end
    wr(8'h3c, 32'h7); rd(8'h3c); `CHK("spdref", 32'h4, v)
    for (int k = 0; k < 8; k++) begin
      wr(8'h34, k); @(posedge clk);
      `CHK("pwr", ~{k[0], k[1], k[2]}, {eth_pwr_en, usb_pwr_en, spi_en})
    end
    tdone("link");
    wr(8'h00, 32'h4); rd(8'h04); `CHK("lock", 1'b1, v[4])
    wr(8'h28, 32'h5a5a); wr(8'h00, 32'h4); fwait(); `CHK("erase", 1'b0, v[4])
    wr(8'h2c, 32'h3); wr(8'h00, 32'h10); fwait(); rd(8'h30); `CHK("blank", 32'hffff_ffff, v)
    d = $urandom; wr(8'h30, d); wr(8'h00, 32'h8); fwait(); wr(8'h00, 32'h10); fwait();
    rd(8'h30); `CHK("fwseg", d, v)
    tdone("firmware");
    for (int w = 0; w < 6; w++) begin
      n = 1 + $urandom % 5; wr(8'h18, w); wr(8'h10, n); wr(8'h08, 32'h5); wr(8'h00, 32'h1);
      wr(8'h00, 32'h1);
      do rd(8'h04); while (!v[1]);
      wr(8'h1c, 32'h0); rd(8'h20); s0 = v[15:0]; `CHK("wave", 4'(w), s0[15:12])
      wr(8'h1c, 32'hf); rd(8'h20); `CHK("trace", later(s0, 15 * n), v[15:0])
    end
    d = $urandom; wr(8'h18, 32'h0); wr(8'h0c, {20'h0, d[11:0]}); wr(8'h08, 32'hc); wr(8'h00, 32'h1);
    do rd(8'h04); while (!v[1]);
    wr(8'h1c, 32'h0); rd(8'h20); `CHK("adcval", {4'h0, 12'(d[11:0] + n)}, v[15:0])
    wr(8'h08, 32'h0); wr(8'h14, 32'h2); wr(8'h00, 32'h1);
    wr(8'h00, 32'h1);
    do rd(8'h04); while (!(v[1] | v[2]));
    `CHK("tout", 2'b10, v[2:1])
    tdone("capture");
    summarize();
  end
endmodule : tb_top
